// file: logic/rsp_pkg.sv
// package: register map, field layout and codes for the radio state policy block
//
// Notes on behaviour
// R1: with carrier-sense termination set, a receive search ends early on a failed RSSI check.
// R2: with termination set and on-off keying, no carrier sense within 8 symbols ends the search.
// R3: at timer expiry reception continues on sync found, or on preamble quality if checked.
// R4: the 3-bit timeout field resets to 7 and 7 means search until end of packet.
// R5: the timeout scales as wake period times a factor that halves per step and grows with res.
// R6: software keeps the wake resolution at 0 or 1 when wake-on-radio is in use.
// R7: software enables the RC oscillator before using timeout settings 0 to 6.
// R8: the timeout count is the upper 13 bits of the wake period at 0, one fewer per step.
// R9: the 2-bit clear-channel mode in bits 5:4 resets to 3 and drives the clear indication.
// R10: clear is always, below RSSI threshold, not receiving a packet, or both, per mode 0..3.
// R11: after packet reception the next state is bits 3:2: idle, synth-ready tx, tx or rx.
// R12: software never pairs a post-receive tx or synth-ready tx with clear-gated transmission.
// R13: after packet transmission the next state is bits 1:0: idle, synth-ready tx, tx or rx.
// R14: unused upper bits of both configuration registers read zero and ignore writes.
package rsp_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0]  RSP_RXT_IDX        = 8'h16;
    localparam logic [7:0]  RSP_PPS_IDX        = 8'h17;
    localparam logic [7:0]  RSP_WAKE_IDX       = 8'h20;
    localparam logic [7:0]  RSP_STAT_IDX       = 8'h21;
    localparam logic [9:0]  RSP_RXT_ADDR       = {RSP_RXT_IDX, 2'b00};
    localparam logic [9:0]  RSP_PPS_ADDR       = {RSP_PPS_IDX, 2'b00};
    localparam logic [9:0]  RSP_WAKE_ADDR      = {RSP_WAKE_IDX, 2'b00};
    localparam logic [9:0]  RSP_STAT_ADDR      = {RSP_STAT_IDX, 2'b00};

    // rx_timeout_config fields
    localparam int          RSP_CS_TERM_BIT    = 4;
    localparam int          RSP_QUAL_BIT       = 3;
    localparam int          RSP_RXTIME_LSB     = 0;
    localparam logic [4:0]  RSP_RXT_RESET      = 5'h07;
    localparam logic [2:0]  RSP_RXTIME_NONE    = 3'h7;

    // post_packet_state_config fields
    localparam int          RSP_CCA_LSB        = 4;
    localparam int          RSP_RXOFF_LSB      = 2;
    localparam int          RSP_TXOFF_LSB      = 0;
    localparam logic [5:0]  RSP_PPS_RESET      = 6'h30;

    // wake config: period in 15:0, resolution in 17:16
    localparam int          RSP_WRES_LSB       = 16;
    localparam logic [15:0] RSP_WAKE_PER_RESET = 16'h8000;
    localparam logic [1:0]  RSP_WRES_RESET     = 2'h0;

    // counting rules
    localparam logic [4:0]  RSP_MSB_DROP       = 5'h03;
    localparam logic [3:0]  RSP_OOK_SYMBOLS    = 4'h8;

    // radio states named by the next-state fields
    localparam logic [1:0]  RSP_ST_IDLE        = 2'h0;
    localparam logic [1:0]  RSP_ST_FSTX        = 2'h1;
    localparam logic [1:0]  RSP_ST_TX          = 2'h2;
    localparam logic [1:0]  RSP_ST_RX          = 2'h3;

    // clear channel modes
    localparam logic [1:0]  RSP_CCA_ALWAYS     = 2'h0;
    localparam logic [1:0]  RSP_CCA_RSSI       = 2'h1;
    localparam logic [1:0]  RSP_CCA_NOPKT      = 2'h2;
    localparam logic [1:0]  RSP_CCA_BOTH       = 2'h3;

    typedef enum logic [1:0] {
        RSP_RX_OFF,
        RSP_RX_SEARCH,
        RSP_RX_HOLD
    } rsp_rx_e;

endpackage

// file: logic/rsp_radio_state_policy.sv
// module: policy registers and receive-timeout logic of the main radio control state machine
`timescale 1ns/1ps
module rsp_radio_state_policy (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rc_tick,
    input  wire logic        symbol_tick,
    input  wire logic        ook_selected,
    input  wire logic        rx_start,
    input  wire logic        rx_stop,
    input  wire logic        rssi_valid,
    input  wire logic        carrier_sense,
    input  wire logic        rssi_below_threshold,
    input  wire logic        receiving_packet,
    input  wire logic        sync_found,
    input  wire logic        preamble_quality_flag,
    input  wire logic        rx_packet_done,
    input  wire logic        tx_packet_done,
    output logic             clear_channel_indication,
    output logic             rx_abort,
    output logic             rx_search_active,
    output logic             next_state_valid,
    output logic      [1:0]  next_state
);

    // ---------------- registers ----------------
    logic [4:0]  rxt_r;
    logic [5:0]  pps_r;
    logic [15:0] wake_event_period_r;
    logic [1:0]  wake_resolution_r;

    wire         access      = psel & penable;
    wire         wr_en       = access & pwrite;
    wire         hit_rxt     = (paddr[9:0] == rsp_pkg::RSP_RXT_ADDR) && (paddr[11:10] == 2'b00);
    wire         hit_pps     = (paddr[9:0] == rsp_pkg::RSP_PPS_ADDR) && (paddr[11:10] == 2'b00);
    wire         hit_wake    = (paddr[9:0] == rsp_pkg::RSP_WAKE_ADDR) && (paddr[11:10] == 2'b00);
    wire         hit_stat    = (paddr[9:0] == rsp_pkg::RSP_STAT_ADDR) && (paddr[11:10] == 2'b00);
    wire         hit_any     = hit_rxt | hit_pps | hit_wake | hit_stat;

    // field views
    wire         carrier_sense_termination = rxt_r[rsp_pkg::RSP_CS_TERM_BIT];
    wire         timeout_quality_check     = rxt_r[rsp_pkg::RSP_QUAL_BIT];
    wire  [2:0]  rx_time                   = rxt_r[rsp_pkg::RSP_RXTIME_LSB +: 3];
    wire  [1:0]  clear_channel_mode        = pps_r[rsp_pkg::RSP_CCA_LSB +: 2];
    wire  [1:0]  after_receive_state       = pps_r[rsp_pkg::RSP_RXOFF_LSB +: 2];
    wire  [1:0]  after_transmit_state      = pps_r[rsp_pkg::RSP_TXOFF_LSB +: 2];

    // single-cycle answer; status register and unmapped addresses are not writable
    assign pready  = 1'b1;
    assign pslverr = access & (~hit_any | (pwrite & hit_stat));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxt_r <= rsp_pkg::RSP_RXT_RESET;
        // R4: timeout field held here, reset 7
        end else if (wr_en && hit_rxt) begin
            // R14: bits 7:5 dropped
            rxt_r <= pwdata[4:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pps_r <= rsp_pkg::RSP_PPS_RESET;
        // R9: clear mode in 5:4, reset 3
        end else if (wr_en && hit_pps) begin
            // R14: bits 7:6 dropped
            pps_r <= pwdata[5:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_event_period_r <= rsp_pkg::RSP_WAKE_PER_RESET;
        end else if (wr_en && hit_wake) begin
            wake_event_period_r <= pwdata[15:0];
        end
    end

    // large resolutions stretch the timeout a lot; nothing here limits them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_resolution_r <= rsp_pkg::RSP_WRES_RESET;
        end else if (wr_en && hit_wake) begin
            wake_resolution_r <= pwdata[rsp_pkg::RSP_WRES_LSB +: 2];
        end
    end

    // ---------------- receive timeout ----------------
    rsp_pkg::rsp_rx_e rx_state_r;
    rsp_pkg::rsp_rx_e rx_state_nxt;
    logic [16:0] tmo_cnt_r;
    logic [16:0] tmo_cnt_nxt;
    logic [3:0]  sym_cnt_r;
    logic [3:0]  sym_cnt_nxt;
    logic        cs_seen_r;
    logic        cs_seen_nxt;
    logic        abort_nxt;
    logic        last_abort_r;
    logic        last_abort_nxt;

    // R8: keep upper 13 bits at setting 0, one fewer per step
    wire  [4:0]  msb_shift   = rsp_pkg::RSP_MSB_DROP + {2'b00, rx_time};
    wire  [15:0] period_msbs = wake_event_period_r >> msb_shift;
    // R5: factor grows 1, 5, 9, 13 with the wake resolution
    wire  [3:0]  res_factor  = {wake_resolution_r, 2'b00} + 4'h1;
    wire  [16:0] tmo_load    = 17'(period_msbs[12:0]) * 17'(res_factor);

    wire         timer_on    = (rx_time != rsp_pkg::RSP_RXTIME_NONE);
    wire         timer_fire  = timer_on & rc_tick & (tmo_cnt_r <= 17'h0_0001);
    // R3: sync word, or preamble quality when checked
    wire         keep_rx     = sync_found | (timeout_quality_check & preamble_quality_flag);
    // R1: failed RSSI check ends the search at once
    wire         cs_fail     = carrier_sense_termination & ~ook_selected &
                               rssi_valid & ~carrier_sense;
    // R2: on-off keying waits 8 symbols for carrier sense
    wire         ook_fail    = carrier_sense_termination & ook_selected & symbol_tick &
                               ~cs_seen_r & ~carrier_sense &
                               (sym_cnt_r == rsp_pkg::RSP_OOK_SYMBOLS - 4'h1);

    // a finished packet whose next state is receive re-arms the search
    wire         rx_rearm    = (rx_packet_done && after_receive_state == rsp_pkg::RSP_ST_RX) ||
                               (tx_packet_done && after_transmit_state == rsp_pkg::RSP_ST_RX);
    wire         arm         = rx_start | rx_rearm;

    // both counters saturate so stray ticks after expiry never wrap them
    wire         tmo_dec     = rc_tick && (tmo_cnt_r != 17'h0_0000);
    wire         sym_inc     = symbol_tick && (sym_cnt_r != rsp_pkg::RSP_OOK_SYMBOLS);
    wire         search_fail = cs_fail | ook_fail;

    always_comb begin
        rx_state_nxt   = rx_state_r;
        tmo_cnt_nxt    = tmo_cnt_r;
        sym_cnt_nxt    = sym_cnt_r;
        cs_seen_nxt    = cs_seen_r | carrier_sense;
        abort_nxt      = 1'b0;
        last_abort_nxt = last_abort_r;
        if (arm) begin
            rx_state_nxt   = rsp_pkg::RSP_RX_SEARCH;
            tmo_cnt_nxt    = tmo_load;
            sym_cnt_nxt    = 4'h0;
            cs_seen_nxt    = 1'b0;
            last_abort_nxt = 1'b0;
        end else if (rx_stop || rx_packet_done) begin
            rx_state_nxt = rsp_pkg::RSP_RX_OFF;
        end else begin
            case (rx_state_r)
                rsp_pkg::RSP_RX_SEARCH: begin
                    if (tmo_dec) begin
                        tmo_cnt_nxt = tmo_cnt_r - 17'h0_0001;
                    end
                    if (sym_inc) begin
                        sym_cnt_nxt = sym_cnt_r + 4'h1;
                    end
                    if (sync_found) begin
                        // packet found; timer no longer matters
                        rx_state_nxt = rsp_pkg::RSP_RX_HOLD;
                    end else if (search_fail) begin
                        rx_state_nxt   = rsp_pkg::RSP_RX_OFF;
                        abort_nxt      = 1'b1;
                        last_abort_nxt = 1'b1;
                    // R4: setting 7 never fires, search runs to packet end
                    end else if (timer_fire) begin
                        // R3: decide at expiry
                        if (keep_rx) begin
                            rx_state_nxt = rsp_pkg::RSP_RX_HOLD;
                        end else begin
                            rx_state_nxt   = rsp_pkg::RSP_RX_OFF;
                            abort_nxt      = 1'b1;
                            last_abort_nxt = 1'b1;
                        end
                    end
                end
                rsp_pkg::RSP_RX_HOLD: begin
                    rx_state_nxt = rsp_pkg::RSP_RX_HOLD;
                end
                rsp_pkg::RSP_RX_OFF: begin
                    rx_state_nxt = rsp_pkg::RSP_RX_OFF;
                end
                default: begin
                    rx_state_nxt = rsp_pkg::RSP_RX_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state_r <= rsp_pkg::RSP_RX_OFF;
        end else begin
            rx_state_r <= rx_state_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tmo_cnt_r <= 17'h0_0000;
        end else begin
            tmo_cnt_r <= tmo_cnt_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sym_cnt_r <= 4'h0;
        end else begin
            sym_cnt_r <= sym_cnt_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_seen_r <= 1'b0;
        end else begin
            cs_seen_r <= cs_seen_nxt;
        end
    end

    // registered so the abort pulse is glitch free and exactly one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_abort <= 1'b0;
        end else begin
            rx_abort <= abort_nxt;
        end
    end

    // sticky until the next arm so software can still read why the search ended
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_abort_r <= 1'b0;
        end else begin
            last_abort_r <= last_abort_nxt;
        end
    end

    assign rx_search_active = (rx_state_r == rsp_pkg::RSP_RX_SEARCH);

    // ---------------- clear channel ----------------
    logic cca_nxt;

    // R10: mode picks the criterion
    always_comb begin
        case (clear_channel_mode)
            rsp_pkg::RSP_CCA_ALWAYS: cca_nxt = 1'b1;
            rsp_pkg::RSP_CCA_RSSI:   cca_nxt = rssi_below_threshold;
            rsp_pkg::RSP_CCA_NOPKT:  cca_nxt = ~receiving_packet;
            rsp_pkg::RSP_CCA_BOTH:   cca_nxt = rssi_below_threshold & ~receiving_packet;
            default:                 cca_nxt = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clear_channel_indication <= 1'b0;
        end else begin
            // R9: presented on the indication output
            clear_channel_indication <= cca_nxt;
        end
    end

    // ---------------- next state after a packet ----------------
    // receive end takes priority if both finish together, radio can only be in one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            next_state_valid <= 1'b0;
        end else begin
            next_state_valid <= rx_packet_done | tx_packet_done;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            next_state <= rsp_pkg::RSP_ST_IDLE;
        end else if (rx_packet_done) begin
            // R11: post-receive state
            next_state <= after_receive_state;
        end else if (tx_packet_done) begin
            // R13: post-transmit state
            next_state <= after_transmit_state;
        end
    end

    // ---------------- read back ----------------
    wire [31:0] rd_rxt  = {27'h000_0000, rxt_r};
    wire [31:0] rd_pps  = {26'h000_0000, pps_r};
    wire [31:0] rd_wake = {14'h0000, wake_resolution_r, wake_event_period_r};
    wire        stat_hold = (rx_state_r == rsp_pkg::RSP_RX_HOLD);
    wire [31:0] rd_stat = {27'h000_0000, clear_channel_indication, last_abort_r,
                           stat_hold, rx_search_active,
                           timer_on};

    // R14: reserved bits return zero
    assign prdata = hit_rxt  ? rd_rxt  :
                    hit_pps  ? rd_pps  :
                    hit_wake ? rd_wake :
                    hit_stat ? rd_stat : 32'h0000_0000;

endmodule

// file: test/rsp_checker.sv
// checker: port-level timing assertions for the radio state policy block
`timescale 1ns/1ps
module rsp_checker (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        rx_start,
    input wire logic        rx_stop,
    input wire logic        sync_found,
    input wire logic        rx_packet_done,
    input wire logic        tx_packet_done,
    input wire logic        rx_abort,
    input wire logic        rx_search_active,
    input wire logic        next_state_valid
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    err_phase_a: assert property (pslverr |-> psel && penable)
        else $error("slave error outside access phase");
    err_rdata_a: assert property (psel && penable && !pwrite && pslverr |-> prdata == '0)
        else $error("refused read returned data");
    cfg_upper_a: assert property (psel && penable && !pwrite
        && paddr == {2'b00, rsp_pkg::RSP_RXT_ADDR} |-> prdata[31:5] == '0)
        else $error("unused timeout config bits read nonzero");
    nsv_follow_a: assert property ((rx_packet_done || tx_packet_done) |=> next_state_valid)
        else $error("next state not reported after packet done");
    nsv_cause_a: assert property (next_state_valid |-> $past(rx_packet_done || tx_packet_done))
        else $error("next state reported without packet done");
    abort_pulse_a: assert property (rx_abort |=> !rx_abort)
        else $error("abort longer than one cycle");
    abort_ends_a: assert property (rx_abort |-> !rx_search_active && $past(rx_search_active))
        else $error("abort without a running search");
    arm_a: assert property (rx_start |=> rx_search_active)
        else $error("search not armed by receive start");
    stop_a: assert property (rx_stop && !rx_start |=> !rx_search_active && !rx_abort)
        else $error("search survived receive stop");
    sync_hold_a: assert property (rx_search_active && sync_found && !rx_start |=> !rx_abort)
        else $error("abort despite sync word found");
    cover property (rx_abort);
    cover property (next_state_valid);
    cover property (pslverr);
endmodule

bind rsp_radio_state_policy rsp_checker u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pslverr(pslverr), .rx_start(rx_start),
    .rx_stop(rx_stop), .sync_found(sync_found), .rx_packet_done(rx_packet_done),
    .tx_packet_done(tx_packet_done), .rx_abort(rx_abort),
    .rx_search_active(rx_search_active), .next_state_valid(next_state_valid));

// file: test/tb.sv
// testbench: register map, next-state, clear-channel and receive-timeout scenarios
`timescale 1ns/1ps
module tb;
    localparam logic [11:0] RXT  = {2'b00, rsp_pkg::RSP_RXT_ADDR};
    localparam logic [11:0] PPS  = {2'b00, rsp_pkg::RSP_PPS_ADDR};
    localparam logic [11:0] WAKE = {2'b00, rsp_pkg::RSP_WAKE_ADDR};
    localparam logic [11:0] STAT = {2'b00, rsp_pkg::RSP_STAT_ADDR};
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic        rc_tick = 1'b0, symbol_tick = 1'b0, ook_selected = 1'b0, rx_start = 1'b0;
    logic        rx_stop = 1'b0, rssi_valid = 1'b0, carrier_sense = 1'b0, sync_found = 1'b0;
    logic        rssi_below_threshold = 1'b0, receiving_packet = 1'b0, rx_packet_done = 1'b0;
    logic        preamble_quality_flag = 1'b0, tx_packet_done = 1'b0;
    logic [31:0] prdata, rdat;
    logic        pready, pslverr, cci, rx_abort, rx_search_active, next_state_valid, rerr;
    logic [1:0]  next_state;
    int          num_errors = 0;
    int          cmp_count = 0;

    always #2.5 pclk = ~pclk;

    rsp_radio_state_policy DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rc_tick(rc_tick), .symbol_tick(symbol_tick), .ook_selected(ook_selected),
        .rx_start(rx_start), .rx_stop(rx_stop), .rssi_valid(rssi_valid),
        .carrier_sense(carrier_sense), .rssi_below_threshold(rssi_below_threshold),
        .receiving_packet(receiving_packet), .sync_found(sync_found),
        .preamble_quality_flag(preamble_quality_flag), .rx_packet_done(rx_packet_done),
        .tx_packet_done(tx_packet_done), .clear_channel_indication(cci),
        .rx_abort(rx_abort), .rx_search_active(rx_search_active),
        .next_state_valid(next_state_valid), .next_state(next_state));

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // entered just after a rising edge; the request is held until pready is sampled
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 50) begin
            num_errors++;
            tally_and_finish();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic e, input string nm);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, rdat, exp);
        chk("pslverr", {31'h0, rerr}, {31'h0, e});
    endtask

    task automatic stop_rx();
        rx_stop <= 1'b1;
        @(posedge pclk);
        rx_stop <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic t_regs();
        rd(RXT, 32'h0000_0007, 1'b0, "rxt reset");
        rd(PPS, 32'h0000_0030, 1'b0, "pps reset");
        rd(WAKE, 32'h0000_8000, 1'b0, "wake reset");
        rd(STAT, 32'h0000_0000, 1'b0, "stat reset");
        apb(1'b1, RXT, 32'hffff_ffff);
        rd(RXT, 32'h0000_001f, 1'b0, "rxt unused");
        apb(1'b1, PPS, 32'hffff_ffc0);
        rd(PPS, 32'h0000_0000, 1'b0, "pps unused");
        rd(12'h100, 32'h0000_0000, 1'b1, "unmapped");
        apb(1'b1, STAT, 32'h0000_00ff);
        chk("status write", {31'h0, rerr}, 32'h0000_0001);
        apb(1'b1, RXT, 32'h0000_0007);
    endtask

    task automatic done_pulse(input logic r, input logic t, input logic [1:0] exp);
        rx_packet_done <= r;
        tx_packet_done <= t;
        @(posedge pclk);
        rx_packet_done <= 1'b0;
        tx_packet_done <= 1'b0;
        @(negedge pclk);
        chk("next valid", {31'h0, next_state_valid}, 32'h0000_0001);
        chk("next state", {30'h0, next_state}, {30'h0, exp});
        @(posedge pclk);
    endtask

    task automatic t_next();
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, PPS, 32'(m * 4 + 3 - m));
            done_pulse(1'b1, 1'b0, 2'(m));
            done_pulse(1'b0, 1'b1, 2'(3 - m));
        end
        // receive completion wins when both finish together
        done_pulse(1'b1, 1'b1, 2'h3);
        stop_rx();
    endtask

    task automatic t_cca();
        logic e;
        for (int md = 0; md < 4; md++) begin
            apb(1'b1, PPS, 32'(md * 16));
            for (int c = 0; c < 4; c++) begin
                rssi_below_threshold <= c[0];
                receiving_packet <= c[1];
                e = (md == 0) | (md == 1 & c[0]) | (md == 2 & !c[1]) | (md == 3 & c[0] & !c[1]);
                repeat (2) @(posedge pclk);
                @(negedge pclk);
                chk("clear channel", {31'h0, cci}, {31'h0, e});
                @(posedge pclk);
            end
        end
    endtask

    // period 0x0400 keeps counts short: 2 ticks at setting 6, 4 at setting 5
    task automatic run(input logic [4:0] cfg, input logic [1:0] res, input logic s,
                       input logic q, input int n, input logic exp);
        logic sa;
        apb(1'b1, WAKE, {14'h0, res, 16'h0400});
        apb(1'b1, RXT, {27'h0, cfg});
        sync_found <= s;
        preamble_quality_flag <= q;
        rx_start <= 1'b1;
        @(posedge pclk);
        rx_start <= 1'b0;
        @(posedge pclk);
        for (int i = 1; i <= n; i++) begin
            rc_tick <= 1'b1;
            @(posedge pclk);
            rc_tick <= 1'b0;
            @(negedge pclk);
            chk("timeout abort", {31'h0, rx_abort}, {31'h0, (i == n) && exp});
            sa = !s && (i < n || cfg[2:0] == 3'h7);
            chk("search active", {31'h0, rx_search_active}, {31'h0, sa});
            @(posedge pclk);
        end
        sync_found <= 1'b0;
        preamble_quality_flag <= 1'b0;
        stop_rx();
    endtask

    task automatic cs_run(input logic ook, input logic cs, input logic exp);
        apb(1'b1, RXT, 32'h0000_0017);
        ook_selected <= ook;
        carrier_sense <= cs;
        rx_start <= 1'b1;
        @(posedge pclk);
        rx_start <= 1'b0;
        @(posedge pclk);
        for (int i = 1; i <= (ook ? 8 : 1); i++) begin
            symbol_tick <= ook;
            rssi_valid <= !ook;
            @(posedge pclk);
            symbol_tick <= 1'b0;
            rssi_valid <= 1'b0;
            @(negedge pclk);
            chk("cs abort", {31'h0, rx_abort}, {31'h0, (i == (ook ? 8 : 1)) && exp});
            @(posedge pclk);
        end
        ook_selected <= 1'b0;
        carrier_sense <= 1'b0;
        stop_rx();
    endtask

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_next();
        t_cca();
        run(5'h06, 2'h0, 1'b0, 1'b0, 2, 1'b1);
        run(5'h05, 2'h0, 1'b0, 1'b0, 4, 1'b1);
        run(5'h06, 2'h1, 1'b0, 1'b0, 10, 1'b1);
        run(5'h06, 2'h0, 1'b0, 1'b1, 2, 1'b1);
        run(5'h0e, 2'h0, 1'b0, 1'b1, 2, 1'b0);
        run(5'h06, 2'h0, 1'b1, 1'b0, 2, 1'b0);
        run(5'h07, 2'h0, 1'b0, 1'b0, 3, 1'b0);
        cs_run(1'b0, 1'b0, 1'b1);
        cs_run(1'b0, 1'b1, 1'b0);
        cs_run(1'b1, 1'b0, 1'b1);
        cs_run(1'b1, 1'b1, 1'b0);
        tally_and_finish();
    end
endmodule
